// ==== core/pwg_pkg.sv ====
// Package for the pulse generator: register map, fields, reset values
package pwg_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] PWG_ON_OFFSET    = 8'h00;
	localparam logic [7:0] PWG_OFF_OFFSET   = 8'h04;
	localparam logic [7:0] PWG_CFG_OFFSET   = 8'h08;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int PWG_CNT_W        = 16;
	localparam int PWG_DIV_W        = 4;
	localparam int PWG_DIV_LSB      = 3;
	localparam int PWG_DIV_MSB      = 6;
	localparam int PWG_INVERT_BIT   = 2;
	localparam int PWG_CLKSEL_BIT   = 1;
	localparam int PWG_ENABLE_BIT   = 0;
	localparam int PWG_CFG_W        = 7;

	// ----------------------------------------
	// Reset values and byte-written masks
	// ----------------------------------------
	localparam logic [15:0] PWG_ON_RESET  = 16'h0000;
	localparam logic [15:0] PWG_OFF_RESET = 16'hFFFF;
	localparam logic [6:0]  PWG_CFG_RESET = 7'h00;
	localparam logic [3:0]  PWG_BYTES_ALL = 4'hF;
	localparam logic [3:0]  PWG_BYTES_ON  = 4'h3;
	localparam logic [3:0]  PWG_BYTES_OFF = 4'hC;

	// Counter phases
	typedef enum logic [1:0] {
		PWG_ST_OFF,
		PWG_ST_ON_PHASE,
		PWG_ST_OFF_PHASE
	} pwg_state_t;

endpackage

// ==== core/pwg_tick_if.sv ====
// Interface carrying tick and control between prescaler and main logic
`timescale 1ns/1ps
interface pwg_tick_if;
	logic       run;
	logic       clk_sel;
	logic [3:0] div;
	logic       tick;

	modport ctrl (output run, output clk_sel, output div, input tick);
	modport gen  (input run, input clk_sel, input div, output tick);
endinterface

// ==== core/pwg_prescaler.sv ====
// Source selection, synchronisation and pre-divider producing counter ticks
`timescale 1ns/1ps
module pwg_prescaler
	import pwg_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic fast_src_clk,
	input  wire logic slow_src_clk,
	pwg_tick_if.gen   tif
);

	// ----------------------------------------
	// Three-stage synchronisers, one per source
	// ----------------------------------------
	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;
	logic [1:0] src_in;
	logic [1:0] stable_q;

	assign src_in = {slow_src_clk, fast_src_clk};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					s1_q[g]     <= 1'b0;
					s2_q[g]     <= 1'b0;
					s3_q[g]     <= 1'b0;
					stable_q[g] <= 1'b0;
				end else begin
					s1_q[g] <= src_in[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g])
						stable_q[g] <= s3_q[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Rising edge of the selected source
	// ----------------------------------------
	logic prev_q;
	logic cur;
	logic src_edge;
	logic [3:0] div_cnt_q;

	assign cur = tif.clk_sel ? stable_q[1] : stable_q[0];

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			prev_q <= 1'b0;
		else
			prev_q <= cur;
	end

	assign src_edge = cur & ~prev_q;

	// Divider held in reset while stopped to save switching
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_cnt_q <= 4'h0;
			tif.tick  <= 1'b0;
		end else if (!tif.run) begin
			div_cnt_q <= 4'h0;
			tif.tick  <= 1'b0;
		end else if (src_edge) begin
			if (div_cnt_q >= tif.div) begin
				div_cnt_q <= 4'h0;
				tif.tick  <= 1'b1;
			end else begin
				div_cnt_q <= div_cnt_q + 4'h1;
				tif.tick  <= 1'b0;
			end
		end else begin
			tif.tick <= 1'b0;
		end
	end

endmodule

// ==== core/pwg_top.sv ====
// Pulse width generator: registers, down counter, phase machine, output
//
// Behaviour
// - Off-time n keeps the output off for n+1 counter ticks.
// - Off-time zero holds the output permanently on.
// - Phases timed by a 16-bit down counter, one step per tick.
// - Pre-divider field bits 6:3 divides the source by value plus one.
// - Pre-divider zero passes the selected source undivided.
// - Invert bit 2 set makes the on level low, clear makes it high.
// - Bit 1 selects slow source when 1, fast source when 0.
// - Clearing enable resets counters and returns the machine to off.
// - While disabled the output sits at its polarity-dependent idle level.
// - On and off time registers stay accessible whatever the enable bit.
// - Disabled block stops all counting logic to save power.
// - Off-time bits 31:16 and configuration bits 31:7 read as zero.
// - On-time n keeps the output on for n+1 counter ticks.
// - On-time zero with nonzero off-time holds the output off.
// - Writes fill holding registers; all four bytes load at off end, or at once while idle or full on.
// - Sleep request clears counters and forces state and output off.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module pwg_top
	import pwg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        fast_src_clk,
	input  wire logic        slow_src_clk,
	input  wire logic        sleep_req,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [31:0]      rdata,
	output logic             pulse_out
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] on_phase_count_q;
	logic [15:0] off_phase_count_q;
	logic [15:0] on_hold_q;
	logic [15:0] off_hold_q;
	logic [3:0]  hold_bytes_q;
	logic [6:0]  cfg_q;
	logic        sleep_q;

	logic        wr_on;
	logic        wr_off;
	logic        wr_cfg;
	logic        hold_full;
	logic        transfer;
	logic        enable;
	logic        invert;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	assign wr_on     = wr_en && (addr == PWG_ON_OFFSET);
	assign wr_off    = wr_en && (addr == PWG_OFF_OFFSET);
	assign wr_cfg    = wr_en && (addr == PWG_CFG_OFFSET);
	assign enable    = cfg_q[PWG_ENABLE_BIT];
	assign invert    = cfg_q[PWG_INVERT_BIT];

	// ----------------------------------------
	// Sleep request
	// ----------------------------------------
	// From logic on the same clock, so one register and no synchroniser
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sleep_q <= 1'b0;
		else
			sleep_q <= sleep_req;
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			cfg_q <= PWG_CFG_RESET;
		else if (wr_cfg)
			cfg_q <= wdata[PWG_CFG_W-1:0];
	end

	// ----------------------------------------
	// Holding registers and byte tracking
	// ----------------------------------------
	// Each 16-bit register is two bytes; a full word write fills both
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			on_hold_q <= PWG_ON_RESET;
		else if (wr_on)
			on_hold_q <= wdata[PWG_CNT_W-1:0];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			off_hold_q <= PWG_OFF_RESET;
		else if (wr_off)
			off_hold_q <= wdata[PWG_CNT_W-1:0];
	end

	// ----------------------------------------
	// Byte-written flags
	// ----------------------------------------
	// Bytes 0 and 1 are the on time, 2 and 3 the off time; a write in
	// the transfer cycle survives, so set wins over clear
	logic [3:0] byte_wr;

	assign byte_wr = (wr_on ? PWG_BYTES_ON : 4'h0)
		| (wr_off ? PWG_BYTES_OFF : 4'h0);

	genvar b;
	generate
		for (b = 0; b < $bits(hold_bytes_q); b++) begin : g_byte
			always_ff @(posedge clk or posedge reset) begin
				if (reset)
					hold_bytes_q[b] <= 1'b0;
				else if (byte_wr[b])
					hold_bytes_q[b] <= 1'b1;
				else if (transfer)
					hold_bytes_q[b] <= 1'b0;
			end
		end
	endgenerate

	assign hold_full = (hold_bytes_q == PWG_BYTES_ALL);

	// ----------------------------------------
	// Phase machine and down counter
	// ----------------------------------------
	pwg_state_t  state_q;
	logic [15:0] cnt_q;
	logic        full_on;
	logic        full_off;
	logic        tick;
	logic        off_end;
	logic        stop;
	logic        cnt_zero;
	logic [15:0] on_load;

	// ----------------------------------------
	// Tick link to the prescaler
	// ----------------------------------------
	// The divider stops with the block, so no tick survives a disable
	pwg_tick_if tif ();

	assign tif.run     = enable && !sleep_q;
	assign tif.clk_sel = cfg_q[PWG_CLKSEL_BIT];
	assign tif.div     = cfg_q[PWG_DIV_MSB:PWG_DIV_LSB];
	assign tick        = tif.tick;

	pwg_prescaler u_prescaler (
		.clk          (clk),
		.reset        (reset),
		.fast_src_clk (fast_src_clk),
		.slow_src_clk (slow_src_clk),
		.tif          (tif)
	);

	assign full_on  = (off_phase_count_q == 16'h0000);
	assign full_off = (on_phase_count_q == 16'h0000) && !full_on;
	assign stop     = !enable || sleep_q;
	assign cnt_zero = (cnt_q == 16'h0000);
	assign off_end  = (state_q == PWG_ST_OFF_PHASE) && tick && cnt_zero;

	// Holding load at the end of the off count, at once when full on, and
	// at once while the machine idles, since no off count is then running
	assign transfer = hold_full
		&& (off_end || full_on || (state_q == PWG_ST_OFF));

	// A transfer in the cycle of an on load hands over the new value
	assign on_load  = transfer ? on_hold_q : on_phase_count_q;

	// ----------------------------------------
	// Active registers
	// ----------------------------------------
	// Software reads these; the counter loads its phase lengths from them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			on_phase_count_q  <= PWG_ON_RESET;
			off_phase_count_q <= PWG_OFF_RESET;
		end else if (transfer) begin
			on_phase_count_q  <= on_hold_q;
			off_phase_count_q <= off_hold_q;
		end
	end

	// ----------------------------------------
	// Phase sequence
	// ----------------------------------------
	// Leaves idle one cycle after enable; the first on phase is only as
	// exact as the arrival of the first tick
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= PWG_ST_OFF;
		end else if (stop) begin
			state_q <= PWG_ST_OFF;
		end else begin
			case (state_q)
				PWG_ST_OFF: begin
					state_q <= PWG_ST_ON_PHASE;
				end
				PWG_ST_ON_PHASE: begin
					if (tick && cnt_zero)
						state_q <= PWG_ST_OFF_PHASE;
				end
				PWG_ST_OFF_PHASE: begin
					if (tick && cnt_zero)
						state_q <= PWG_ST_ON_PHASE;
				end
				default: begin
					state_q <= PWG_ST_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Down counter
	// ----------------------------------------
	// Sits at zero while stopped; loads a phase length at each change
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 16'h0000;
		end else if (stop) begin
			cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				PWG_ST_OFF: begin
					cnt_q <= on_load;
				end
				PWG_ST_ON_PHASE: begin
					if (tick && cnt_zero)
						cnt_q <= off_phase_count_q;
					else if (tick)
						cnt_q <= cnt_q - 16'h0001;
				end
				PWG_ST_OFF_PHASE: begin
					if (tick && cnt_zero)
						cnt_q <= on_load;
					else if (tick)
						cnt_q <= cnt_q - 16'h0001;
				end
				default: begin
					cnt_q <= 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Output pin
	// ----------------------------------------
	logic on_level;

	// Disable and sleep win, then full on, then full off, then the phase;
	// the invert bit is applied last so the idle level follows it
	always_comb begin
		if (stop)
			on_level = 1'b0;
		else if (full_on)
			on_level = 1'b1;
		else if (full_off)
			on_level = 1'b0;
		else
			on_level = (state_q == PWG_ST_ON_PHASE);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pulse_out <= 1'b0;
		else
			pulse_out <= on_level ^ invert;
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Reads return the active registers, never the holding ones
	logic [31:0] read_word;

	always_comb begin
		read_word = 32'h0000_0000;
		case (addr)
			PWG_ON_OFFSET:  read_word = {16'h0, on_phase_count_q};
			PWG_OFF_OFFSET: read_word = {16'h0, off_phase_count_q};
			PWG_CFG_OFFSET: read_word = {25'h0, cfg_q};
			default:        read_word = 32'h0000_0000;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rdata <= 32'h0000_0000;
		else if (rd_en)
			rdata <= read_word;
		else
			rdata <= 32'h0000_0000;
	end

endmodule

// ==== dv/pwg_monitor.sv ====
// Port checks for the pulse generator
`timescale 1ns/1ps
module pwg_monitor
	import pwg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        sleep_req,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [31:0] rdata,
	input  wire logic        pulse_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [6:0] cfg_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			cfg_q <= PWG_CFG_RESET;
		else if (wr_en && addr == PWG_CFG_OFFSET)
			cfg_q <= wdata[6:0];
	end
	a_read_idle_zero: assert property (
		!rd_en |=> rdata == 32'h0) else $error("rdata not idle");
	a_off_upper_zero: assert property (
		rd_en && addr == PWG_OFF_OFFSET |=> rdata[31:16] == 16'h0)
		else $error("off upper bits set");
	a_cfg_upper_zero: assert property (
		rd_en && addr == PWG_CFG_OFFSET |=> rdata[31:7] == 25'h0)
		else $error("cfg upper bits set");
	a_cfg_read_back: assert property (
		rd_en && addr == PWG_CFG_OFFSET |=> rdata[6:0] == $past(cfg_q))
		else $error("cfg readback wrong");
	a_unmapped_zero: assert property (
		rd_en && addr > PWG_CFG_OFFSET |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_disabled_idle: assert property (
		(!cfg_q[0] && $stable(cfg_q))[*4] |-> pulse_out == cfg_q[2])
		else $error("disabled output not idle");
	a_sleep_idle: assert property (
		(sleep_req && $stable(cfg_q))[*4] |-> pulse_out == cfg_q[2])
		else $error("sleep output not idle");
	a_reset_off: assert property (
		$fell(reset) |-> (pulse_out == 1'b0)[*3])
		else $error("output active after reset");
endmodule
bind pwg_top pwg_monitor u_mon (.clk(clk), .reset(reset),
	.sleep_req(sleep_req), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .pulse_out(pulse_out));

// ==== dv/pwg_load_model.sv ====
// Load on the output pin: measures active and idle run lengths
`timescale 1ns/1ps
module pwg_load_model (
	input  wire logic        clk,
	input  wire logic        pin,
	input  wire logic        inv,
	output logic [31:0]      on_len,
	output logic [31:0]      off_len,
	output logic [31:0]      edges
);
	logic        pin_q = 1'b0;
	logic [31:0] run_q = 32'h0;
	initial edges = 32'h0;
	always @(posedge clk) begin
		if (pin !== pin_q) begin
			if (pin_q !== inv)
				on_len <= run_q;
			else
				off_len <= run_q;
			run_q <= 32'h1;
			edges <= edges + 32'h1;
		end else
			run_q <= run_q + 32'h1;
		pin_q <= pin;
	end
endmodule

// ==== dv/tb_pwm_duty_frequency_gen.sv ====
// Self-checking bench for the pulse generator
`timescale 1ns/1ps
module tb_pwm_duty_frequency_gen;
	import pwg_pkg::*;
	logic        clk, reset, fast_src_clk, slow_src_clk, sleep_req;
	logic        wr_en, rd_en, pulse_out, inv;
	logic [7:0]  addr;
	logic [6:0]  cfg_v;
	logic [15:0] on_v, off_v;
	logic [31:0] wdata, rdata, on_len, off_len, edges, rng, e0;
	int          mismatches, samples_checked;
	pwg_top DUT (.clk(clk), .reset(reset), .fast_src_clk(fast_src_clk),
		.slow_src_clk(slow_src_clk), .sleep_req(sleep_req), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.pulse_out(pulse_out));
	pwg_load_model u_load (.clk(clk), .pin(pulse_out), .inv(inv),
		.on_len(on_len), .off_len(off_len), .edges(edges));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		fast_src_clk = 1'b0;
		forever #50 fast_src_clk = ~fast_src_clk;
	end
	initial begin
		slow_src_clk = 1'b0;
		forever #150 slow_src_clk = ~slow_src_clk;
	end
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Clocks per phase: ticks times divider times source period
	function automatic logic [31:0] exp_len(input logic [15:0] n,
		input logic [6:0] c);
		return (n + 32'h1) * (c[6:3] + 32'h1) * (c[1] ? 32'h3C : 32'h14);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 check(rdata, e);
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#500000;
		mismatches++;
		end_sim();
	end
	initial begin
		reset = 1'b1;
		{sleep_req, wr_en, rd_en, inv, addr, wdata} = '0;
		mismatches = 0;
		samples_checked = 0;
		rng = 32'h37A6;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(PWG_ON_OFFSET, 32'h0);
		rd(PWG_OFF_OFFSET, 32'hFFFF);
		rd(PWG_CFG_OFFSET, 32'h0);
		wr(8'h0C, 32'hFFFFFFFF);
		rd(8'h0C, 32'h0);
		wr(PWG_CFG_OFFSET, 32'hFFFFFFF8);
		rd(PWG_CFG_OFFSET, 32'h78);
		for (int i = 0; i < 8; i++) begin
			rng = next_rand(rng);
			on_v = (i == 1) ? 16'h0 : {14'h0, rng[1:0]} + 16'h1;
			off_v = (i == 0) ? 16'h0 : {14'h0, rng[3:2]} + 16'h1;
			// Hand-set corners: undivided source, then the slow source
			cfg_v = {2'b00, ((i == 2) ? 2'b00 : rng[5:4]), rng[8],
				rng[9] | (i == 3), 1'b0};
			inv = rng[8];
			wr(PWG_CFG_OFFSET, {25'h0, cfg_v});
			wr(PWG_ON_OFFSET, {rng[31:16], on_v});
			wr(PWG_OFF_OFFSET, {rng[31:16], off_v});
			repeat (4) @(posedge clk);
			rd(PWG_ON_OFFSET, {16'h0, on_v});
			rd(PWG_OFF_OFFSET, {16'h0, off_v});
			check({31'h0, pulse_out}, {31'h0, inv});
			e0 = edges;
			wr(PWG_CFG_OFFSET, {25'h0, cfg_v | 7'h01});
			if (on_v == 16'h0 || off_v == 16'h0) begin
				repeat (2000) @(posedge clk);
				check(edges - e0, {31'h0, off_v == 16'h0});
			end else begin
				for (int k = 0; k < 20000 && edges < e0 + 4; k++)
					@(posedge clk);
				check(on_len, exp_len(on_v, cfg_v));
				check(off_len, exp_len(off_v, cfg_v));
				wr(PWG_ON_OFFSET, 32'h7);
				rd(PWG_ON_OFFSET, {16'h0, on_v});
				wr(PWG_OFF_OFFSET, 32'h3);
				repeat (2600) @(posedge clk);
				rd(PWG_ON_OFFSET, 32'h7);
				rd(PWG_OFF_OFFSET, 32'h3);
			end
			sleep_req <= 1'b1;
			repeat (50) @(posedge clk);
			check({31'h0, pulse_out}, {31'h0, inv});
			sleep_req <= 1'b0;
			repeat (300) @(posedge clk);
			wr(PWG_CFG_OFFSET, {25'h0, cfg_v});
			repeat (8) @(posedge clk);
			check({31'h0, pulse_out}, {31'h0, inv});
		end
		end_sim();
	end
endmodule
